//--- design/adst_timer.sv
`timescale 1ns/1ps
`include "adst_cfg.svh"
module adst_timer
   import adst_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // oscillator pin, counted in its rising edges
   input wire logic oscillatorInput,
   // timing fields and control from software
   input wire logic [`ADST_SMP_W-1:0] sampleCountField,
   input wire logic [`ADST_CONVERT_COUNT_FIELD_W-1:0] convertCountField,
   input wire logic tenBitMode,
   input wire logic startConv,
   // analog side
   output logic sampleSwitch,
   output logic converting,
   output logic convDone,
   output logic rangeError
);
   adst_state_t state;
   adst_state_t next_state;
   logic oscMeta;
   logic oscSync;
   logic oscLast;
   logic [`ADST_CNT_W-1:0] count;
   logic [`ADST_CNT_W-1:0] next_count;
   logic [`ADST_SMP_W-1:0] smpLatch;
   logic [`ADST_CONVERT_COUNT_FIELD_W-1:0] convLatch;
   logic bitsLatch;

   // oscillator edge detect after two flops
   wire oscTick = oscSync & ~oscLast;
   wire [3:0] bitCount = bitsLatch ? `ADST_BITS_HI : `ADST_BITS_LO;
   // sample length of the latched field, in oscillator periods
   wire [`ADST_CNT_W-1:0] sampleLen =
      `ADST_CNT_W'(smpLatch * `ADST_SMP_MUL + `ADST_SMP_ADD);
   // sample length of the field being started, loaded on the same edge as the latch
   wire [`ADST_CNT_W-1:0] startLen =
      `ADST_CNT_W'(sampleCountField * `ADST_SMP_MUL + `ADST_SMP_ADD);
   // conversion length in oscillator periods
   wire [`ADST_CNT_W-1:0] convLen = `ADST_CNT_W'(
      (`ADST_CNT_W'(convLatch) + `ADST_CONVERT_COUNT_FIELD_INC) * `ADST_CONVERT_COUNT_FIELD_MUL
      * `ADST_CNT_W'(bitCount) + `ADST_CONVERT_COUNT_FIELD_ADD);
   wire lastTick = oscTick && (count == `ADST_CNT_LAST);
   // out-of-range fields are flagged, not corrected
   wire badFields = (sampleCountField < `ADST_SMP_MIN) ||
      (convertCountField < `ADST_CONVERT_COUNT_FIELD_MIN);

   // pin synchroniser
   // only the second flop reads the first; the third feeds the edge detect
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         oscMeta <= 1'b0;
         oscSync <= 1'b0;
         oscLast <= 1'b0;
      end
      else
      begin
         oscMeta <= oscillatorInput;
         oscSync <= oscMeta;
         oscLast <= oscSync;
      end
   end

   // next state and count
   // a start while busy is dropped with no indication
   always_comb
   begin
      next_state = state;
      next_count = count;
      case (state)
         ADST_IDLE:
            if (startConv)
            begin
               next_state = ADST_SAMPLE;
               next_count = startLen;
            end
         ADST_SAMPLE:
            if (lastTick)
            begin
               next_state = ADST_CONVERT;
               next_count = convLen;
            end
            else if (oscTick)
               next_count = count - `ADST_CNT_STEP;
         ADST_CONVERT:
            if (lastTick)
               next_state = ADST_IDLE;
            else if (oscTick)
               next_count = count - `ADST_CNT_STEP;
         default:
            next_state = ADST_IDLE;
      endcase
   end

   // state and count registers
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= ADST_IDLE;
         count <= '0;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
      end
   end

   // fields held for the whole conversion
   // so a late field change cannot stretch or cut a running phase
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         smpLatch <= `ADST_SMP_MIN;
         convLatch <= `ADST_CONVERT_COUNT_FIELD_MIN;
         bitsLatch <= 1'b0;
      end
      else if (state == ADST_IDLE && startConv)
      begin
         smpLatch <= sampleCountField;
         convLatch <= convertCountField;
         bitsLatch <= tenBitMode;
      end
   end

   // outputs
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sampleSwitch <= 1'b0;
         converting <= 1'b0;
         convDone <= 1'b0;
         rangeError <= 1'b0;
      end
      else
      begin
         sampleSwitch <= (next_state == ADST_SAMPLE);
         converting <= (next_state == ADST_CONVERT);
         convDone <= (state == ADST_CONVERT) && lastTick;
         // flag reflects the fields of the latest accepted start
         if (state == ADST_IDLE && startConv)
            rangeError <= badFields;
      end
   end

   // switch closed only in sample phase
   switch_excl_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      !(sampleSwitch && converting))
      else $error("sample switch closed while converting");
   // strobes follow the phase register
   phase_match_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      sampleSwitch == (state == ADST_SAMPLE) &&
      converting == (state == ADST_CONVERT))
      else $error("phase strobes out of step");
   // conversion begins right after sampling
   convert_count_field_follows_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      $fell(sampleSwitch) |-> converting)
      else $error("conversion did not follow sampling");
   // sample length reload
   sample_load_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state == ADST_IDLE && startConv) |=> count == sampleLen)
      else $error("sample count loaded wrong");
   // conversion length reload
   convert_count_field_load_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state == ADST_SAMPLE && lastTick) |=> count == convLen)
      else $error("conversion count loaded wrong");
   // busy phases never run on an empty count
   count_live_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state != ADST_IDLE) |-> count != '0)
      else $error("count empty while busy");
   // done after conversion only
   done_pulse_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      convDone |-> $past(converting) && !converting && !sampleSwitch)
      else $error("done pulse out of place");
   // done lasts one cycle
   done_single_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      convDone |=> !convDone)
      else $error("done pulse longer than one cycle");
   // bit count taken at start
   bits_latch_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state == ADST_IDLE && startConv) |=> bitsLatch == $past(tenBitMode))
      else $error("bit count not latched at start");
   // busy start leaves the latched fields alone
   busy_hold_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state != ADST_IDLE && startConv) |=>
      $stable(smpLatch) && $stable(convLatch) && $stable(bitsLatch))
      else $error("fields changed during conversion");
   // count moves only on oscillator ticks while busy
   tick_step_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state != ADST_IDLE && !oscTick) |=> $stable(count))
      else $error("count moved without tick");
   // range flag
   range_flag_a: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state == ADST_IDLE && startConv) |=> rangeError == $past(badFields))
      else $error("range flag wrong");
endmodule

//--- pkg/adst_cfg.svh
`ifndef ADST_CFG_SVH
`define ADST_CFG_SVH
// oscillator input to system clock ratio: 250 MHz / 16 MHz is not whole,
// so the oscillator input is a pin sampled and edge detected
`define ADST_SMP_W 3
`define ADST_CONVERT_COUNT_FIELD_W 5
`define ADST_SMP_MUL 4'h8
`define ADST_SMP_ADD 7'h02
`define ADST_CONVERT_COUNT_FIELD_ADD 10'h003
`define ADST_CONVERT_COUNT_FIELD_INC 10'h001
`define ADST_CONVERT_COUNT_FIELD_MUL 10'h002
`define ADST_BITS_LO 4'h8
`define ADST_BITS_HI 4'ha
`define ADST_SMP_MIN 3'h1
`define ADST_SMP_MAX 3'h7
`define ADST_CONVERT_COUNT_FIELD_MIN 5'h02
`define ADST_CONVERT_COUNT_FIELD_MAX 5'h1f
`define ADST_CNT_W 10
`define ADST_CNT_STEP 10'h001
`define ADST_CNT_LAST 10'h001
`endif

//--- pkg/adst_pkg.sv
package adst_pkg;
   typedef enum logic [1:0] {ADST_IDLE, ADST_SAMPLE, ADST_CONVERT} adst_state_t;
endpackage

//--- test/adst_analog_model.sv
`timescale 1ns/1ps
module adst_analog_model (
   // oscillator source
   output logic oscillatorInput,
   // phase strobes seen from the timer
   input wire logic sys_clk,
   input wire logic sampleSwitch,
   input wire logic converting,
   // cycles counted in each phase
   output int sampleCycles,
   output int convCycles
);
   logic oscLevel = 1'b0;
   int smpCnt = 0;
   int cvtCnt = 0;
   // 64 ns period, exactly 16 system clocks per tick
   always #32 oscLevel = ~oscLevel;
   assign oscillatorInput = oscLevel;
   assign sampleCycles = smpCnt;
   assign convCycles = cvtCnt;
   // capacitor charges only while switch closed, then held
   always @(posedge sys_clk)
   begin
      if (sampleSwitch)
         smpCnt <= smpCnt + 1;
      if (converting)
         cvtCnt <= cvtCnt + 1;
   end
endmodule

//--- test/adst_timer_tb.sv
`timescale 1ns/1ps
module adst_timer_tb;
   import adst_pkg::*;
   logic sys_clk = 1'b0, rstn = 1'b0, osc, ten = 1'b0, start = 1'b0;
   logic [2:0] smpIn = 3'h1;
   logic [4:0] cnv = 5'h02;
   logic swOn, convOn, done, rngErr;
   int sc, cc, err_total = 0, num_checks = 0;
   logic hung = 1'b0;
   always #2 sys_clk = ~sys_clk;
   adst_timer dut (.sys_clk(sys_clk), .rstn(rstn), .oscillatorInput(osc),
      .sampleCountField(smpIn), .convertCountField(cnv), .tenBitMode(ten),
      .startConv(start), .sampleSwitch(swOn), .converting(convOn),
      .convDone(done), .rangeError(rngErr));
   adst_analog_model far (.oscillatorInput(osc), .sys_clk(sys_clk),
      .sampleSwitch(swOn), .converting(convOn), .sampleCycles(sc),
      .convCycles(cc));
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task check_bit(input string n, input logic e, input logic s);
      num_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", n, e, s);
      end
   endtask
   task check_int(input string n, input int e, input int s);
      num_checks++;
      if (s != e)
      begin
         err_total++;
         $display("MISMATCH %s expected %0d seen %0d", n, e, s);
      end
   endtask
   // one conversion; poke repeats start while busy, fields left alone
   task run_convert_count_field(input logic [2:0] s, input logic [4:0] c, input logic t,
      input logic expErr, input logic poke);
      int s0, c0, n1, n2, k;
      if (hung)
         return;
      s0 = sc;
      c0 = cc;
      n1 = s * 8 + 2;
      n2 = (c + 1) * 2 * (t ? 10 : 8) + 3;
      smpIn = s;
      cnv = c;
      ten = t; // fields written only while idle
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      check_bit("rangeError", expErr, rngErr);
      k = 0;
      while (done !== 1'b1 && k < 20000)
      begin
         @(negedge sys_clk);
         k++;
         start = poke && (k == 20);
      end
      if (k >= 20000)
      begin
         err_total++;
         hung = 1'b1;
         $display("MISMATCH convDone expected 1 seen %b", done);
         return;
      end
      check_int("sampleTicks", n1, (sc - s0 + 15) / 16);
      check_int("convCycles", n2 * 16, cc - c0);
      @(negedge sys_clk);
      check_bit("converting", 1'b0, convOn);
      check_bit("convDone", 1'b0, done);
      $display("test sample %0d convert %0d ten %b done", s, c, t);
   endtask
   // shortest legal timing, 8 bits
   task test_min_fields;
      run_convert_count_field(3'h1, 5'h02, 1'b0, 1'b0, 1'b0);
   endtask
   // longest legal timing, 10 bits
   task test_max_fields;
      run_convert_count_field(3'h7, 5'h1f, 1'b1, 1'b0, 1'b0);
   endtask
   // start repeated mid-conversion is ignored
   task test_busy_start;
      run_convert_count_field(3'h3, 5'h05, 1'b1, 1'b0, 1'b1);
   endtask
   // fields below range are flagged
   task test_bad_fields;
      run_convert_count_field(3'h0, 5'h01, 1'b0, 1'b1, 1'b0);
   endtask
   // counts that meet the converter sample and conversion limits
   task test_in_spec;
      run_convert_count_field(3'h4, 5'h09, 1'b0, 1'b0, 1'b0);
   endtask
   initial
   begin
      repeat (3) @(negedge sys_clk);
      rstn = 1'b1;
      check_bit("sampleSwitch", 1'b0, swOn);
      check_bit("converting", 1'b0, convOn);
      test_min_fields;
      test_max_fields;
      test_busy_start;
      test_bad_fields;
      test_in_spec;
      print_verdict;
   end
endmodule
